// ---- rtl/uhr_uart.sv ----
// serial transceiver: holding registers, fifos, mask and status logic
// What this block does
// - host write loads the transmit holding byte when fifo has room
// - transmit-holding-empty flag sets when empty or byte moves to shifter
// - host read returns oldest received byte and pops it
// - falling edge starts 16x count; mid start sample must be low
// - mask bit 7 raises interrupt on CTS pin rising
// - mask bit 6 raises interrupt on RTS pin rising
// - mask bit 5 enables interrupt on received Xoff character
// - mask bit 4 enables sleep mode
// - mask bit 3 lets modem status changes interrupt
// - mask bit 2 gates receive line status interrupt
// - mask bit 1 gates holding-empty interrupt mirroring status bit
// - mask bit 0 gates receive ready, trigger level in fifo mode
// - mask register resets to zero
// - enabled sources drive interrupt pin; masked ones suppressed
// - source register shows receive trigger, clears below level
// - data ready sets on push, holds until receive fifo empty
// - fifo mode with mask bits 0..3 clear is polled operation
// - status bits 1..4 report receive error types
// - status bit 5 is one when transmit fifo empty
// - status bit 6 one when transmit fifo and shifter empty
// - status bit 7 flags an errored byte in receive fifo
module uhr_uart
  import uhr_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       cs_n_i,
  input  wire logic       rd_n_i,
  input  wire logic       wr_n_i,
  input  wire logic [2:0] addr_i,
  input  wire logic [7:0] data_i,
  output logic      [7:0] data_o,
  output logic            data_oe_n_o,
  input  wire logic       rx_i,
  output logic            tx_o,
  input  wire logic [3:0] modem_n_i,
  output logic            rts_n_o,
  output logic            dtr_n_o,
  input  wire logic [7:0] xoff_char_i,
  output logic            sleep_en_o,
  output logic            int_o
);
  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    ptr_inc = p + 5'h01;
  endfunction

  function automatic logic [CNT_W-1:0] trig_lvl(input logic [1:0] sel);
    case (sel)
      2'h0:    trig_lvl = TRIG_L0;
      2'h1:    trig_lvl = TRIG_L1;
      2'h2:    trig_lvl = TRIG_L2;
      default: trig_lvl = TRIG_L3;
    endcase
  endfunction

  uhr_pins_t pins_in;
  uhr_pins_t pins_s1_r;
  uhr_pins_t pins_s2_r;
  uhr_pins_t pins_s3_r;
  logic [7:0]  ier_r;
  logic [7:0]  fcr_r;
  logic [7:0]  lcr_r;
  logic [7:0]  mcr_r;
  logic [7:0]  spr_r;
  logic [15:0] div_r;
  logic [15:0] div_cnt_r;
  logic        tick;
  logic        rd_go;
  logic        wr_go;
  logic        dlab;
  logic        fifo_en;
  logic [CNT_W-1:0] cap;
  logic [7:0]  rd_val;
  logic [7:0]  rdata_r;
  logic        oe_r;

  assign pins_in = '{cs_n: cs_n_i, rd_n: rd_n_i, wr_n: wr_n_i, addr: addr_i,
                     data: data_i, rx: rx_i, modem_n: modem_n_i};

  // two-stage synchroniser, third stage only for edges
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pins_s1_r <= PINS_IDLE;
      pins_s2_r <= PINS_IDLE;
      pins_s3_r <= PINS_IDLE;
    end else begin
      pins_s1_r <= pins_in;
      pins_s2_r <= pins_s1_r;
      pins_s3_r <= pins_s2_r;
    end
  end

  assign rd_go = !pins_s2_r.cs_n && !pins_s2_r.rd_n &&
                 (pins_s3_r.cs_n || pins_s3_r.rd_n);
  assign wr_go = !pins_s2_r.cs_n && !pins_s2_r.wr_n &&
                 (pins_s3_r.cs_n || pins_s3_r.wr_n);
  assign dlab    = lcr_r[LCR_DLAB];
  assign fifo_en = fcr_r[FCR_EN];
  assign cap     = fifo_en ? CNT_FULL : CNT_ONE;

  logic thr_wr;
  logic rhr_rd;
  logic isr_rd;
  logic lsr_rd;
  logic msr_rd;
  logic fcr_wr;
  assign thr_wr = wr_go && pins_s2_r.addr == ADDR_HOLD && !dlab;
  assign rhr_rd = rd_go && pins_s2_r.addr == ADDR_HOLD && !dlab;
  assign isr_rd = rd_go && pins_s2_r.addr == ADDR_FIFO;
  assign lsr_rd = rd_go && pins_s2_r.addr == ADDR_LSR;
  assign msr_rd = rd_go && pins_s2_r.addr == ADDR_MSR;
  assign fcr_wr = wr_go && pins_s2_r.addr == ADDR_FIFO;

  // host-written registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ier_r <= IER_RESET;
      fcr_r <= FCR_RESET;
      lcr_r <= LCR_RESET;
      mcr_r <= MCR_RESET;
      spr_r <= SPR_RESET;
      div_r <= DIV_RESET;
    end else if (wr_go) begin
      case (pins_s2_r.addr)
        ADDR_HOLD: if (dlab) div_r[7:0] <= pins_s2_r.data;
        ADDR_IER:
          if (dlab) div_r[15:8] <= pins_s2_r.data;
          else ier_r <= pins_s2_r.data;
        ADDR_FIFO: fcr_r <= pins_s2_r.data & 8'hF9;
        ADDR_LCR:  lcr_r <= pins_s2_r.data;
        ADDR_MCR:  mcr_r <= pins_s2_r.data;
        ADDR_SPR:  spr_r <= pins_s2_r.data;
        default:   ;
      endcase
    end
  end

  // 16x sample enable from divisor
  always_ff @(posedge clk_i) begin
    if (rst_i) div_cnt_r <= 16'h0000;
    else if (tick) div_cnt_r <= 16'h0000;
    else div_cnt_r <= div_cnt_r + 16'h0001;
  end
  assign tick = (div_cnt_r + 16'h0001) >= div_r;

  logic fifo_clr_rx;
  logic fifo_clr_tx;
  logic fen_chg;
  assign fen_chg     = fcr_wr && (pins_s2_r.data[FCR_EN] != fifo_en);
  assign fifo_clr_rx = fcr_wr && (pins_s2_r.data[FCR_RXRST] || fen_chg);
  assign fifo_clr_tx = fcr_wr && (pins_s2_r.data[FCR_TXRST] || fen_chg);

  // transmit fifo
  logic [7:0]       tx_mem [FIFO_DEPTH];
  logic [PTR_W-1:0] tx_wp_r;
  logic [PTR_W-1:0] tx_rp_r;
  logic [CNT_W-1:0] tx_cnt_r;
  logic             tx_push;
  logic             tx_pop;
  uhr_ser_t         tx_st_r;
  assign tx_push = thr_wr && (tx_cnt_r < cap);
  assign tx_pop  = tx_st_r == SER_IDLE && tx_cnt_r != 6'h00;

  always_ff @(posedge clk_i) begin
    if (tx_push) tx_mem[tx_wp_r] <= pins_s2_r.data;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || fifo_clr_tx) begin
      tx_wp_r  <= '0;
      tx_rp_r  <= '0;
      tx_cnt_r <= '0;
    end else begin
      if (tx_push) tx_wp_r <= ptr_inc(tx_wp_r);
      if (tx_pop) tx_rp_r <= ptr_inc(tx_rp_r);
      tx_cnt_r <= tx_cnt_r + {5'h00, tx_push} - {5'h00, tx_pop};
    end
  end

  // transmit shifter, 8 data bits, optional parity, one stop
  logic [7:0] tx_sh_r;
  logic [3:0] tx_tc_r;
  logic [2:0] tx_bn_r;
  logic       tx_par_r;
  logic       tx_line_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_st_r   <= SER_IDLE;
      tx_sh_r   <= 8'h00;
      tx_tc_r   <= 4'h0;
      tx_bn_r   <= 3'h0;
      tx_par_r  <= 1'b0;
      tx_line_r <= 1'b1;
    end else begin
      case (tx_st_r)
        SER_IDLE: begin
          tx_line_r <= 1'b1;
          if (tx_pop) begin
            tx_sh_r  <= tx_mem[tx_rp_r];
            tx_par_r <= ^tx_mem[tx_rp_r] ^ ~lcr_r[LCR_EPS];
            tx_tc_r  <= 4'h0;
            tx_st_r  <= SER_START;
          end
        end
        default: if (tick) begin
          tx_tc_r <= tx_tc_r + 4'h1;
          case (tx_st_r)
            SER_START: tx_line_r <= 1'b0;
            SER_DATA:  tx_line_r <= tx_sh_r[0];
            SER_PAR:   tx_line_r <= tx_par_r;
            default:   tx_line_r <= 1'b1;
          endcase
          if (tx_tc_r == BIT_LAST) begin
            case (tx_st_r)
              SER_START: begin
                tx_st_r <= SER_DATA;
                tx_bn_r <= 3'h0;
              end
              SER_DATA: begin
                tx_sh_r <= {1'b0, tx_sh_r[7:1]};
                tx_bn_r <= tx_bn_r + 3'h1;
                if (tx_bn_r == DATA_LAST)
                  tx_st_r <= lcr_r[LCR_PEN] ? SER_PAR : SER_STOP;
              end
              SER_PAR: tx_st_r <= SER_STOP;
              default: tx_st_r <= SER_IDLE;
            endcase
          end
        end
      endcase
    end
  end
  assign tx_o = tx_line_r && !lcr_r[LCR_BRK];

  // receiver
  uhr_ser_t   rx_st_r;
  logic [7:0] rx_sh_r;
  logic [3:0] rx_tc_r;
  logic [2:0] rx_bn_r;
  logic       rx_pe_r;
  logic       rx_fall;
  logic       rx_push;
  uhr_rx_entry_t rx_ent;
  assign rx_fall = pins_s3_r.rx && !pins_s2_r.rx;
  assign rx_push = rx_st_r == SER_STOP && tick && rx_tc_r == BIT_LAST;
  assign rx_ent  = '{brk: !pins_s2_r.rx && rx_sh_r == 8'h00,
                     frm: !pins_s2_r.rx, par: rx_pe_r, data: rx_sh_r};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_st_r <= SER_IDLE;
      rx_sh_r <= 8'h00;
      rx_tc_r <= 4'h0;
      rx_bn_r <= 3'h0;
      rx_pe_r <= 1'b0;
    end else begin
      case (rx_st_r)
        SER_IDLE: if (rx_fall) begin
          rx_tc_r <= 4'h0;
          rx_st_r <= SER_START;
        end
        SER_START: if (tick) begin
          rx_tc_r <= rx_tc_r + 4'h1;
          if (rx_tc_r == START_MID) begin
            rx_tc_r <= 4'h0;
            rx_bn_r <= 3'h0;
            rx_pe_r <= 1'b0;
            rx_st_r <= pins_s2_r.rx ? SER_IDLE : SER_DATA;
          end
        end
        default: if (tick) begin
          rx_tc_r <= rx_tc_r + 4'h1;
          if (rx_tc_r == BIT_LAST) begin
            case (rx_st_r)
              SER_DATA: begin
                rx_sh_r <= {pins_s2_r.rx, rx_sh_r[7:1]};
                rx_bn_r <= rx_bn_r + 3'h1;
                if (rx_bn_r == DATA_LAST)
                  rx_st_r <= lcr_r[LCR_PEN] ? SER_PAR : SER_STOP;
              end
              SER_PAR: begin
                rx_pe_r <= pins_s2_r.rx != (^rx_sh_r ^ ~lcr_r[LCR_EPS]);
                rx_st_r <= SER_STOP;
              end
              default: rx_st_r <= SER_IDLE;
            endcase
          end
        end
      endcase
    end
  end

  // receive fifo with error tags
  uhr_rx_entry_t    rx_mem [FIFO_DEPTH];
  logic [PTR_W-1:0] rx_wp_r;
  logic [PTR_W-1:0] rx_rp_r;
  logic [CNT_W-1:0] rx_cnt_r;
  logic [CNT_W-1:0] rx_ecnt_r;
  logic             rx_wr;
  logic             rx_pop;
  logic             rx_ovr;
  logic             ent_err;
  logic             top_err;
  assign rx_ovr  = rx_push && rx_cnt_r >= cap;
  assign rx_wr   = rx_push && !rx_ovr;
  assign rx_pop  = rhr_rd && rx_cnt_r != 6'h00;
  assign ent_err = rx_ent.brk || rx_ent.frm || rx_ent.par;
  assign top_err = rx_mem[rx_rp_r].brk || rx_mem[rx_rp_r].frm ||
                   rx_mem[rx_rp_r].par;

  always_ff @(posedge clk_i) begin
    if (rx_wr) rx_mem[rx_wp_r] <= rx_ent;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || fifo_clr_rx) begin
      rx_wp_r   <= '0;
      rx_rp_r   <= '0;
      rx_cnt_r  <= '0;
      rx_ecnt_r <= '0;
    end else begin
      if (rx_wr) rx_wp_r <= ptr_inc(rx_wp_r);
      if (rx_pop) rx_rp_r <= ptr_inc(rx_rp_r);
      rx_cnt_r <= rx_cnt_r + {5'h00, rx_wr} - {5'h00, rx_pop};
      rx_ecnt_r <= rx_ecnt_r + {5'h00, rx_wr && ent_err} -
                   {5'h00, rx_pop && top_err};
    end
  end

  // sticky line errors: overrun, parity, framing, break
  logic [3:0] lsr_err_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) lsr_err_r <= 4'h0;
    else lsr_err_r <= (lsr_rd ? 4'h0 : lsr_err_r) |
                      {rx_wr && rx_ent.brk, rx_wr && rx_ent.frm,
                       rx_wr && rx_ent.par, rx_ovr};
  end

  logic [7:0] line_status_reg;
  assign line_status_reg = {rx_ecnt_r != 6'h00,
                tx_cnt_r == 6'h00 && tx_st_r == SER_IDLE,
                tx_cnt_r == 6'h00,
                lsr_err_r,
                rx_cnt_r != 6'h00};

  // modem status and flow events
  logic [3:0] mdm_now;
  logic [3:0] msr_dlt_r;
  logic       cts_evt_r;
  logic       rts_evt_r;
  logic       xoff_evt_r;
  logic       rts_rise;
  assign mdm_now  = ~pins_s2_r.modem_n;
  assign rts_rise = wr_go && pins_s2_r.addr == ADDR_MCR &&
                    mcr_r[MCR_RTS] && !pins_s2_r.data[MCR_RTS];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      msr_dlt_r  <= 4'h0;
      cts_evt_r  <= 1'b0;
      rts_evt_r  <= 1'b0;
      xoff_evt_r <= 1'b0;
    end else begin
      msr_dlt_r <= (msr_rd ? 4'h0 : msr_dlt_r) |
                   (pins_s2_r.modem_n ^ pins_s3_r.modem_n);
      cts_evt_r <= (cts_evt_r && !isr_rd) ||
                   (pins_s2_r.modem_n[MDM_CTS] &&
                    !pins_s3_r.modem_n[MDM_CTS]);
      rts_evt_r <= (rts_evt_r && !isr_rd) || rts_rise;
      xoff_evt_r <= (xoff_evt_r && !isr_rd) ||
                    (rx_wr && rx_ent.data == xoff_char_i);
    end
  end

  // interrupt sources, priority and pin
  logic       s_ls, s_rx, s_tx, s_ms, s_xoff, s_flow;
  logic [4:0] src;
  logic       pend;
  assign s_ls   = ier_r[IER_LS] && lsr_err_r != 4'h0;
  assign s_rx   = ier_r[IER_RX] && (fifo_en ?
                  rx_cnt_r >= trig_lvl(fcr_r[7:6]) :
                  rx_cnt_r != 6'h00);
  assign s_tx   = ier_r[IER_TX] && line_status_reg[5];
  assign s_ms   = ier_r[IER_MS] && msr_dlt_r != 4'h0;
  assign s_xoff = ier_r[IER_XOFF] && xoff_evt_r;
  assign s_flow = (ier_r[IER_CTS] && cts_evt_r) ||
                  (ier_r[IER_RTS] && rts_evt_r);
  assign pend   = s_ls || s_rx || s_tx || s_ms || s_xoff || s_flow;

  always_comb begin
    src = SRC_MS;
    if (s_ls) src = SRC_LS;
    else if (s_rx) src = SRC_RX;
    else if (s_tx) src = SRC_TX;
    else if (s_ms) src = SRC_MS;
    else if (s_xoff) src = SRC_XOFF;
    else if (s_flow) src = SRC_FLOW;
  end

  logic int_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) int_r <= 1'b0;
    else int_r <= pend;
  end
  assign int_o      = int_r;
  assign sleep_en_o = ier_r[IER_SLEEP];
  assign rts_n_o    = !mcr_r[MCR_RTS];
  assign dtr_n_o    = !mcr_r[MCR_DTR];

  // read mux and bus drive
  always_comb begin
    case (pins_s2_r.addr)
      ADDR_HOLD: rd_val = dlab ? div_r[7:0] : rx_mem[rx_rp_r].data;
      ADDR_IER:  rd_val = dlab ? div_r[15:8] : ier_r;
      ADDR_FIFO: rd_val = {fifo_en, fifo_en, src, !pend};
      ADDR_LCR:  rd_val = lcr_r;
      ADDR_MCR:  rd_val = mcr_r;
      ADDR_LSR:  rd_val = line_status_reg;
      ADDR_MSR:  rd_val = {mdm_now, msr_dlt_r};
      default:   rd_val = spr_r;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_r <= 8'h00;
      oe_r    <= 1'b0;
    end else begin
      if (rd_go) rdata_r <= rd_val;
      oe_r <= !pins_s2_r.cs_n && !pins_s2_r.rd_n;
    end
  end
  assign data_o      = rdata_r;
  assign data_oe_n_o = !oe_r;
endmodule

// ---- rtl/uhr_pkg.sv ----
// constants and types for the serial transceiver holding/interrupt block
package uhr_pkg;
  localparam int unsigned FIFO_DEPTH = 32;
  localparam int unsigned PTR_W      = 5;
  localparam int unsigned CNT_W      = 6;
  localparam logic [CNT_W-1:0] CNT_ONE  = 6'h01;
  localparam logic [CNT_W-1:0] CNT_FULL = 6'h20;
  // host register addresses
  localparam logic [2:0] ADDR_HOLD = 3'h0;
  localparam logic [2:0] ADDR_IER  = 3'h1;
  localparam logic [2:0] ADDR_FIFO = 3'h2;
  localparam logic [2:0] ADDR_LCR  = 3'h3;
  localparam logic [2:0] ADDR_MCR  = 3'h4;
  localparam logic [2:0] ADDR_LSR  = 3'h5;
  localparam logic [2:0] ADDR_MSR  = 3'h6;
  localparam logic [2:0] ADDR_SPR  = 3'h7;
  // reset values
  localparam logic [7:0]  IER_RESET = 8'h00;
  localparam logic [7:0]  FCR_RESET = 8'h00;
  localparam logic [7:0]  LCR_RESET = 8'h00;
  localparam logic [7:0]  MCR_RESET = 8'h00;
  localparam logic [7:0]  SPR_RESET = 8'hFF;
  localparam logic [15:0] DIV_RESET = 16'h0001;
  // field positions
  localparam int unsigned IER_RX    = 0;
  localparam int unsigned IER_TX    = 1;
  localparam int unsigned IER_LS    = 2;
  localparam int unsigned IER_MS    = 3;
  localparam int unsigned IER_SLEEP = 4;
  localparam int unsigned IER_XOFF  = 5;
  localparam int unsigned IER_RTS   = 6;
  localparam int unsigned IER_CTS   = 7;
  localparam int unsigned FCR_EN    = 0;
  localparam int unsigned FCR_RXRST = 1;
  localparam int unsigned FCR_TXRST = 2;
  localparam int unsigned LCR_PEN   = 3;
  localparam int unsigned LCR_EPS   = 4;
  localparam int unsigned LCR_BRK   = 6;
  localparam int unsigned LCR_DLAB  = 7;
  localparam int unsigned MCR_DTR   = 0;
  localparam int unsigned MCR_RTS   = 1;
  localparam int unsigned MDM_CTS   = 0;
  // interrupt source codes, bits 5:1 of the source register
  localparam logic [4:0] SRC_LS   = 5'h03;
  localparam logic [4:0] SRC_RX   = 5'h02;
  localparam logic [4:0] SRC_TX   = 5'h01;
  localparam logic [4:0] SRC_MS   = 5'h00;
  localparam logic [4:0] SRC_XOFF = 5'h08;
  localparam logic [4:0] SRC_FLOW = 5'h10;
  // receive trigger levels selected by fifo control bits 7:6
  localparam logic [CNT_W-1:0] TRIG_L0 = 6'h01;
  localparam logic [CNT_W-1:0] TRIG_L1 = 6'h08;
  localparam logic [CNT_W-1:0] TRIG_L2 = 6'h10;
  localparam logic [CNT_W-1:0] TRIG_L3 = 6'h1C;
  // 16x sample timing
  localparam logic [3:0] START_MID = 4'h7;
  localparam logic [3:0] BIT_LAST  = 4'hF;
  localparam logic [2:0] DATA_LAST = 3'h7;

  typedef struct packed {
    logic       cs_n;
    logic       rd_n;
    logic       wr_n;
    logic [2:0] addr;
    logic [7:0] data;
    logic       rx;
    logic [3:0] modem_n;
  } uhr_pins_t;
  localparam uhr_pins_t PINS_IDLE = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                                      addr: 3'h0, data: 8'h00, rx: 1'b1,
                                      modem_n: 4'hF};

  typedef struct packed {
    logic       brk;
    logic       frm;
    logic       par;
    logic [7:0] data;
  } uhr_rx_entry_t;

  typedef enum logic [2:0] {
    SER_IDLE, SER_START, SER_DATA, SER_PAR, SER_STOP
  } uhr_ser_t;
endpackage

// ---- sim/uhr_monitor.sv ----
// assertion checker for the holding register and interrupt mask block
module uhr_monitor
  import uhr_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       cs_n_i,
  input wire logic       rd_n_i,
  input wire logic       wr_n_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] data_i,
  input wire logic [7:0] data_o,
  input wire logic       data_oe_n_o,
  input wire logic       tx_o,
  input wire logic [3:0] modem_n_i,
  input wire logic       rts_n_o,
  input wire logic       dtr_n_o,
  input wire logic       sleep_en_o,
  input wire logic       int_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       wr_r;
  logic       ier_w_r;
  logic       dlab_r;
  logic [7:0] m_new_r;
  logic [7:0] m_old_r;
  wire  logic wr_on = !(wr_n_i | cs_n_i);

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // mask shadow: new at strobe start, old until strobe end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_r    <= 1'b0;
      ier_w_r <= 1'b0;
      dlab_r  <= 1'b0;
      m_new_r <= 8'h00;
      m_old_r <= 8'h00;
    end else begin
      wr_r <= wr_on;
      if (wr_on && !wr_r) begin
        ier_w_r <= addr_i == ADDR_IER && !dlab_r;
        if (addr_i == ADDR_IER && !dlab_r) m_new_r <= data_i;
        if (addr_i == ADDR_LCR) dlab_r <= data_i[LCR_DLAB];
      end
      if (!wr_on && wr_r) m_old_r <= m_new_r;
    end
  end

  a_reset_quiet: assert property ($fell(rst_i) |-> !int_o &&
    !sleep_en_o && tx_o && data_oe_n_o && rts_n_o && dtr_n_o)
    else $error("outputs not idle after reset");
  a_read_drives: assert property ($fell(data_oe_n_o) |->
    !$past(rd_n_i, 2) && !$past(cs_n_i, 2))
    else $error("bus driven without a read strobe");
  a_sleep_tracks: assert property (!wr_on && wr_r && ier_w_r |->
    sleep_en_o == m_new_r[IER_SLEEP])
    else $error("sleep enable differs from mask bit");
  a_int_masked: assert property (int_o |->
    (m_new_r | m_old_r) != 8'h00)
    else $error("interrupt with all mask bits clear");
  a_cts_irq: assert property ($rose(modem_n_i[MDM_CTS]) &&
    m_new_r[IER_CTS] && m_old_r[IER_CTS] |-> ##[1:8] int_o)
    else $error("no interrupt on cts rising");
  a_rts_irq: assert property ($rose(rts_n_o) && m_new_r[IER_RTS] &&
    m_old_r[IER_RTS] |-> ##[1:6] int_o)
    else $error("no interrupt on rts rising");
  a_modem_irq: assert property ($changed(modem_n_i) &&
    m_new_r[IER_MS] && m_old_r[IER_MS] |-> ##[1:8] int_o)
    else $error("no interrupt on modem change");
  a_empty_order: assert property ($fell(data_oe_n_o) &&
    addr_i == ADDR_LSR |-> !data_o[6] || data_o[5])
    else $error("shifter empty flagged with fifo not empty");
endmodule

bind uhr_uart uhr_monitor u_mon (
  .clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n_i), .rd_n_i(rd_n_i),
  .wr_n_i(wr_n_i), .addr_i(addr_i), .data_i(data_i), .data_o(data_o),
  .data_oe_n_o(data_oe_n_o), .tx_o(tx_o), .modem_n_i(modem_n_i),
  .rts_n_o(rts_n_o), .dtr_n_o(dtr_n_o), .sleep_en_o(sleep_en_o),
  .int_o(int_o)
);

// ---- sim/uhr_serial_peer.sv ----
// remote serial partner: sends and collects 8n1 characters
module uhr_serial_peer (
  input  wire logic clk_i,
  input  wire logic line_i,
  output logic      line_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got_q[$];
  logic [7:0] sh;

  initial line_o = 1'b1;

  // one frame, 16 clocks a bit, stop level chosen by caller
  task automatic send(input logic [7:0] b, input logic stp);
    line_o <= 1'b0;
    repeat (16) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      line_o <= b[i];
      repeat (16) @(posedge clk_i);
    end
    line_o <= stp;
    repeat (16) @(posedge clk_i);
    line_o <= 1'b1;
    repeat (16) @(posedge clk_i);
  endtask

  // short low pulse that must not count as a start
  task automatic glitch(input int n);
    line_o <= 1'b0;
    repeat (n) @(posedge clk_i);
    line_o <= 1'b1;
    repeat (32) @(posedge clk_i);
  endtask

  // collect bytes from the transmit line, sampled mid bit
  always begin
    @(negedge line_i);
    repeat (8) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (16) @(posedge clk_i);
      sh[i] = line_i;
    end
    got_q.push_back(sh);
    repeat (16) @(posedge clk_i);
  end
endmodule

// ---- sim/uart_holding_regs_irq_enable_tb_top.sv ----
// testbench for the holding register and interrupt mask block
module uart_holding_regs_irq_enable_tb_top
  import uhr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        rxl;
  logic [7:0]  data_o;
  logic        data_oe_n_o;
  logic        tx_o;
  logic        rts_n_o;
  logic        dtr_n_o;
  logic        sleep_en_o;
  logic        int_o;
  logic [7:0]  rv;
  logic        oe_seen;
  uhr_pins_t   pin = PINS_IDLE;
  int          n_errors = 0;
  int          n_checks = 0;
  // rows: write flag, address, write data or expected read
  logic [11:0] rows [7] = '{12'h100, 12'h560, 12'h910, 12'h110,
                            12'h900, 12'hA41, 12'h560};

  always #20 clk_i = ~clk_i;

  uhr_uart u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .cs_n_i(pin.cs_n), .rd_n_i(pin.rd_n),
    .wr_n_i(pin.wr_n), .addr_i(pin.addr), .data_i(pin.data),
    .data_o(data_o), .data_oe_n_o(data_oe_n_o), .rx_i(rxl), .tx_o(tx_o),
    .modem_n_i(pin.modem_n), .rts_n_o(rts_n_o), .dtr_n_o(dtr_n_o),
    .xoff_char_i(8'h13), .sleep_en_o(sleep_en_o), .int_o(int_o)
  );
  uhr_serial_peer u_peer (.clk_i(clk_i), .line_i(tx_o), .line_o(rxl));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] s);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, s);
    end
  endtask

  // one host access: strobe held 6 clocks, then 4 clocks idle
  task automatic acc(input logic w, input logic [2:0] a,
                     input logic [7:0] d);
    pin.cs_n <= 1'b0;
    pin.rd_n <= w;
    pin.wr_n <= !w;
    pin.addr <= a;
    pin.data <= d;
    repeat (6) @(posedge clk_i);
    rv = data_o;
    oe_seen = data_oe_n_o;
    pin.cs_n <= 1'b1;
    pin.rd_n <= 1'b1;
    pin.wr_n <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk($sformatf("read addr %0d", a), e, rv);
    chk("data_oe_n_o", 8'h00, {7'h00, oe_seen});
  endtask

  task automatic wait_int(input logic v);
    int k;
    k = 0;
    while (int_o !== v && k < 400) begin
      @(posedge clk_i);
      k++;
    end
    chk("int_o", {7'h00, v}, {7'h00, int_o});
    if (k == 400) complete_run();
  endtask

  task automatic done(input string t);
    $display("test %s done", t);
  endtask

  initial begin
    repeat (60000) @(posedge clk_i);
    n_errors++;
    complete_run();
  end

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 7; i++) begin
      acc(rows[i][11], rows[i][10:8], rows[i][7:0]);
      if (!rows[i][11]) chk("row read", rows[i][7:0], rv);
      if (i == 2) chk("sleep_en_o", 8'h01, {7'h00, sleep_en_o});
      chk("int_o", 8'h00, {7'h00, int_o});
    end
    done("table");
    u_peer.glitch(5);
    rd(ADDR_LSR, 8'h60);
    done("false start");
    wr(ADDR_IER, 8'h01);
    for (int i = 0; i < 8; i++) begin
      chk("int_o", 8'h00, {7'h00, int_o});
      u_peer.send(8'h30 + 8'(i), 1'b1);
    end
    wait_int(1'b1);
    rd(ADDR_FIFO, {2'b11, SRC_RX, 1'b0});
    rd(ADDR_HOLD, 8'h30);
    wait_int(1'b0);
    rd(ADDR_LSR, 8'h61);
    for (int i = 1; i < 8; i++) rd(ADDR_HOLD, 8'h30 + 8'(i));
    rd(ADDR_LSR, 8'h60);
    done("receive trigger");
    wr(ADDR_IER, 8'h04);
    u_peer.send(8'h55, 1'b0);
    wait_int(1'b1);
    rd(ADDR_LSR, 8'hE9);
    rd(ADDR_HOLD, 8'h55);
    rd(ADDR_LSR, 8'h60);
    done("framing");
    wr(ADDR_IER, 8'h20);
    u_peer.send(8'h13, 1'b1);
    wait_int(1'b1);
    rd(ADDR_FIFO, 8'hD0);
    wait_int(1'b0);
    rd(ADDR_HOLD, 8'h13);
    done("xoff");
    wr(ADDR_IER, 8'h02);
    wait_int(1'b1);
    wr(ADDR_HOLD, 8'h5A);
    rd(ADDR_LSR, 8'h20);
    for (int k = 0; k < 400 && u_peer.got_q.size() == 0; k++)
      @(posedge clk_i);
    if (u_peer.got_q.size() == 0) begin
      n_errors++;
      complete_run();
    end
    chk("serial out", 8'h5A, u_peer.got_q[0]);
    repeat (32) @(posedge clk_i);
    rd(ADDR_LSR, 8'h60);
    done("transmit");
    wr(ADDR_IER, 8'h80);
    pin.modem_n[0] <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk("int_o", 8'h00, {7'h00, int_o});
    pin.modem_n[0] <= 1'b1;
    wait_int(1'b1);
    rd(ADDR_FIFO, 8'hE0);
    wait_int(1'b0);
    wr(ADDR_IER, 8'h40);
    wr(ADDR_MCR, 8'h03);
    chk("rts_dtr", 8'h00, {6'h00, rts_n_o, dtr_n_o});
    wr(ADDR_MCR, 8'h00);
    wait_int(1'b1);
    rd(ADDR_FIFO, 8'hE0);
    acc(1'b0, ADDR_MSR, 8'h00);
    wr(ADDR_IER, 8'h08);
    chk("int_o", 8'h00, {7'h00, int_o});
    pin.modem_n[1] <= 1'b0;
    wait_int(1'b1);
    done("modem");
    wr(ADDR_IER, 8'hFF);
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(ADDR_IER, 8'h00);
    chk("sleep_en_o", 8'h00, {7'h00, sleep_en_o});
    done("reset");
    complete_run();
  end
endmodule
